// ### core/rx_mon_pkg.sv
// Purpose: Shared constants and types for the receive line monitor.
// Assumes: One 100 MHz clock; one received symbol pair per byte strobe.
// Notes: Register indices are word offsets.
package rx_mon_pkg;

  // ----------------------------------------------------------------------
  // Line state codes and symbol codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] LS_ACTIVE = 3'h0;
  localparam logic [2:0] LS_IDLE = 3'h1;
  localparam logic [2:0] LS_NO_SIGNAL = 3'h2;
  localparam logic [2:0] LS_MASTER = 3'h4;
  localparam logic [2:0] LS_HALT = 3'h5;
  localparam logic [2:0] LS_QUIET = 3'h6;
  localparam logic [2:0] LS_NOISE = 3'h7;

  localparam logic [3:0] SYM_QUIET = 4'h0;
  localparam logic [3:0] SYM_HALT = 4'h1;
  localparam logic [3:0] SYM_VIOL = 4'h3;
  localparam logic [3:0] SYM_END = 4'h5;
  localparam logic [3:0] SYM_RESET = 4'h6;
  localparam logic [3:0] SYM_SET = 4'h7;
  localparam logic [3:0] SYM_IDLE = 4'hA;
  localparam logic [3:0] SYM_START_J = 4'hD;
  localparam logic [3:0] SYM_START_K = 4'hD;

  // ----------------------------------------------------------------------
  // Output code fields
  // ----------------------------------------------------------------------
  localparam logic [3:0] RX_STATE_INVALID = 4'h3;
  localparam logic [3:0] RX_STATE_IDLE = 4'hB;
  localparam logic [3:0] DATA_ZERO = 4'h0;
  localparam logic [7:0] CODE_EB_ERROR = 8'h3B;
  localparam logic [7:0] CODE_INVALID_CONN = 8'h3A;
  localparam logic [7:0] CODE_SCRUB = 8'hB8;
  localparam int KNOWN_BIT = 3;

  // ----------------------------------------------------------------------
  // Timing and widths
  // ----------------------------------------------------------------------
  localparam int SUPER_IDLE_PAIRS = 8;
  localparam int SUPER_IDLE_EXTRA = 1;
  localparam int NOISE_W = 16;
  localparam int PRESCALE_W = 8;
  localparam int LINK_W = 8;
  localparam int EVENT_W = 16;

  // ----------------------------------------------------------------------
  // Register map (word index) and reset values
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_NOISE_THRESH = 4'h2;
  localparam logic [3:0] REG_PRESCALE_THRESH = 4'h3;
  localparam logic [3:0] REG_LINK_THRESH = 4'h4;
  localparam logic [3:0] REG_NOISE_SNAP = 4'h5;
  localparam logic [3:0] REG_PRESCALE_SNAP = 4'h6;
  localparam logic [3:0] REG_LINK_SNAP = 4'h7;
  localparam logic [3:0] REG_NOISE_EVENTS = 4'h8;

  localparam int CTRL_STOP = 0;
  localparam int STAT_NOISE_EXPIRED = 0;
  localparam int STAT_LINK_EXPIRED = 1;
  localparam int STAT_LINK_FLAG = 2;
  localparam int STAT_SUPER_IDLE = 3;

  localparam logic [NOISE_W-1:0] NOISE_THRESH_RESET = 16'hFFFF;
  localparam logic [PRESCALE_W-1:0] PRESCALE_THRESH_RESET = 8'hFF;
  localparam logic [LINK_W-1:0] LINK_THRESH_RESET = 8'hFF;

endpackage

// ### core/down_counter.sv
// Purpose: Loadable down counter that holds at zero.
// Assumes: Load has priority over decrement.
// Notes: Serves noise, prescale and link counts.
`timescale 1ns/1ns
module down_counter #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VALUE = '1
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic load_in,
  input wire logic [W-1:0] load_value_in,
  input wire logic dec_in,
  output logic [W-1:0] count_out,
  output logic zero_out
);

  typedef struct packed {
    logic [W-1:0] count;
  } cnt_state_t;

  cnt_state_t st;
  cnt_state_t next_st;

  always_comb begin
    next_st = st;
    if (load_in) begin
      next_st.count = load_value_in;
    end else if (dec_in && st.count != '0) begin
      next_st.count = st.count - W'(1);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st.count <= RESET_VALUE;
    end else begin
      st <= next_st;
    end
  end

  assign count_out = st.count;
  assign zero_out = (st.count == '0);

endmodule

// ### core/super_idle_detect.sv
// Purpose: Flags a run of idle pairs in idle line state.
// Assumes: One strobe per received symbol pair.
// Notes: The flag drops on the first pair that breaks the run.
`timescale 1ns/1ns
module super_idle_detect import rx_mon_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic clear_in,
  input wire logic byte_valid_in,
  input wire logic idle_pair_in,
  output logic super_idle_out
);

  localparam int RUN = SUPER_IDLE_PAIRS + SUPER_IDLE_EXTRA;

  typedef struct packed {
    logic [3:0] run;
    logic flag;
  } idle_state_t;

  idle_state_t st;
  idle_state_t next_st;

  always_comb begin
    next_st = st;
    if (clear_in) begin
      next_st.run = 4'h0;
      next_st.flag = 1'b0;
    end else if (byte_valid_in) begin
      if (!idle_pair_in) begin
        next_st.run = 4'h0;
      end else if (st.run != 4'(RUN)) begin
        next_st.run = st.run + 4'h1;
      end
      // Flag on the ninth idle pair in a row.
      next_st.flag = idle_pair_in && (st.run + 4'h1 >= 4'(RUN));
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign super_idle_out = st.flag;

endmodule

// ### core/rx_line_monitor_byte_encoder.sv
// Purpose: Receive line monitor, noise and link error timing, byte coder.
// Assumes: Symbol pairs and line state arrive from logic on sys_clk_in.
// Notes: Registers are reached over Avalon-MM with one wait cycle.
`timescale 1ns/1ns
module rx_line_monitor_byte_encoder import rx_mon_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic byte_valid_in,
  input wire logic sym_a_ctrl_in,
  input wire logic [3:0] sym_a_in,
  input wire logic sym_b_ctrl_in,
  input wire logic [3:0] sym_b_in,
  input wire logic [2:0] line_state_in,
  input wire logic unknown_line_state_in,
  input wire logic signal_detect_in,
  input wire logic clock_detect_in,
  input wire logic stuff_byte_in,
  input wire logic eb_error_in,
  input wire logic invalid_connection_in,
  input wire logic scrub_pair_in,
  output logic code_valid_out,
  output logic code_ctrl_out,
  output logic [7:0] code_out,
  output logic super_idle_state_out,
  output logic noise_expired_out,
  output logic noise_event_out,
  output logic link_error_flag_out
);

  // ----------------------------------------------------------------------
  // Symbol pair decoding
  // ----------------------------------------------------------------------
  function automatic logic is_sym(input logic c, input logic [3:0] s,
                                  input logic [3:0] want);
    return c && (s == want);
  endfunction

  // Data or R, S, T: the first symbol class of a noise pair.
  function automatic logic is_a(input logic c, input logic [3:0] s);
    return !c || is_sym(c, s, SYM_RESET) || is_sym(c, s, SYM_SET) ||
           is_sym(c, s, SYM_END);
  endfunction

  function automatic logic is_b(input logic c, input logic [3:0] s);
    return is_a(c, s) || is_sym(c, s, SYM_IDLE);
  endfunction

  typedef struct packed {
    logic stop;
    logic [NOISE_W-1:0] noise_thresh;
    logic [PRESCALE_W-1:0] prescale_thresh;
    logic [LINK_W-1:0] link_thresh;
    logic noise_sticky;
    logic link_sticky;
    logic link_flag;
    logic [EVENT_W-1:0] event_count;
    logic noise_event;
    logic [2:0] prev_ls;
    logic prev_unknown;
    logic prev_ii;
    logic noise_zero_q;
    logic link_zero_q;
    logic ack;
    logic [31:0] rdata;
    logic code_valid;
    logic code_ctrl;
    logic [7:0] code;
  } mon_state_t;

  mon_state_t st;
  mon_state_t next_st;

  logic pair_ii;
  logic pair_jk;
  logic pair_hh;
  logic pair_hi;
  logic pair_ab;
  logic pair_t;
  logic in_als;
  logic in_ils;
  logic phy_invalid;
  logic link_set;
  logic link_clear;
  logic noise_dec;
  logic noise_reload;
  logic pre_zero;
  logic main_zero;
  logic link_zero;
  logic [NOISE_W-1:0] noise_count;
  logic [PRESCALE_W-1:0] pre_count;
  logic [LINK_W-1:0] link_count;
  logic super_idle;
  logic state_match;
  logic bus_access;

  assign pair_ii = is_sym(sym_a_ctrl_in, sym_a_in, SYM_IDLE) &&
                   is_sym(sym_b_ctrl_in, sym_b_in, SYM_IDLE);
  assign pair_jk = is_sym(sym_a_ctrl_in, sym_a_in, SYM_START_J) &&
                   is_sym(sym_b_ctrl_in, sym_b_in, SYM_START_K);
  assign pair_hh = is_sym(sym_a_ctrl_in, sym_a_in, SYM_HALT) &&
                   is_sym(sym_b_ctrl_in, sym_b_in, SYM_HALT);
  assign pair_hi = is_sym(sym_a_ctrl_in, sym_a_in, SYM_HALT) &&
                   is_sym(sym_b_ctrl_in, sym_b_in, SYM_IDLE);
  assign pair_ab = is_a(sym_a_ctrl_in, sym_a_in) &&
                   is_b(sym_b_ctrl_in, sym_b_in);
  assign pair_t = is_sym(sym_a_ctrl_in, sym_a_in, SYM_END) ||
                  is_sym(sym_b_ctrl_in, sym_b_in, SYM_END);

  // A start delimiter is treated as active at once.
  assign in_als = !unknown_line_state_in &&
                  (line_state_in == LS_ACTIVE || pair_jk);
  assign in_ils = !unknown_line_state_in && !pair_jk &&
                  line_state_in == LS_IDLE;

  // ----------------------------------------------------------------------
  // Noise events and link errors
  // ----------------------------------------------------------------------
  always_comb begin
    phy_invalid = 1'b0;
    if (unknown_line_state_in) begin
      phy_invalid = (st.prev_ls == LS_ACTIVE || st.prev_ls == LS_IDLE);
    end else begin
      unique case (line_state_in)
        LS_HALT, LS_QUIET, LS_MASTER, LS_NOISE: phy_invalid = 1'b1;
        default: phy_invalid = 1'b0;
      endcase
    end
  end

  // Halt second symbol after H, converted data, R, S or T.
  assign link_set = byte_valid_in && in_als &&
                    is_sym(sym_b_ctrl_in, sym_b_in, SYM_HALT) &&
                    (!sym_a_ctrl_in ||
                     is_sym(sym_a_ctrl_in, sym_a_in, SYM_HALT) ||
                     is_sym(sym_a_ctrl_in, sym_a_in, SYM_RESET) ||
                     is_sym(sym_a_ctrl_in, sym_a_in, SYM_SET) ||
                     is_sym(sym_a_ctrl_in, sym_a_in, SYM_END));

  assign link_clear = byte_valid_in &&
                      (((in_als || in_ils) && pair_jk) ||
                       (unknown_line_state_in &&
                        st.prev_ls == LS_ACTIVE && st.link_flag &&
                        !stuff_byte_in &&
                        !(pair_hh || pair_hi || pair_ii || pair_jk)));

  // ----------------------------------------------------------------------
  // Noise timer and counters
  // ----------------------------------------------------------------------
  // Line states that count down the timer.
  assign noise_dec = byte_valid_in && !noise_reload &&
                     (unknown_line_state_in || line_state_in == LS_NOISE ||
                      line_state_in == LS_ACTIVE);

  // Settled states and delimiters reload the timer.
  assign noise_reload = st.stop ||
                        (byte_valid_in && (pair_jk || pair_t ||
                         (!unknown_line_state_in &&
                          line_state_in != LS_ACTIVE &&
                          line_state_in != LS_NOISE)));

  down_counter #(
    .W(PRESCALE_W),
    .RESET_VALUE(PRESCALE_THRESH_RESET)
  ) u_prescale (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .load_in(noise_reload || (noise_dec && pre_zero)),
    .load_value_in(st.prescale_thresh),
    .dec_in(noise_dec && !pre_zero),
    .count_out(pre_count),
    .zero_out(pre_zero)
  );

  down_counter #(
    .W(NOISE_W),
    .RESET_VALUE(NOISE_THRESH_RESET)
  ) u_noise (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .load_in(noise_reload),
    .load_value_in(st.noise_thresh),
    .dec_in(noise_dec && pre_zero),
    .count_out(noise_count),
    .zero_out(main_zero)
  );

  // Each new link error steps the count.
  down_counter #(
    .W(LINK_W),
    .RESET_VALUE(LINK_THRESH_RESET)
  ) u_link (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .load_in(st.stop),
    .load_value_in(st.link_thresh),
    .dec_in(link_set && !st.link_flag),
    .count_out(link_count),
    .zero_out(link_zero)
  );

  super_idle_detect u_idle (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .clear_in(st.stop),
    .byte_valid_in(byte_valid_in),
    .idle_pair_in(in_ils && pair_ii),
    .super_idle_out(super_idle)
  );

  // ----------------------------------------------------------------------
  // Pair matches line state
  // ----------------------------------------------------------------------
  always_comb begin
    state_match = 1'b0;
    if (!unknown_line_state_in) begin
      unique case (line_state_in)
        LS_HALT: state_match = pair_hh;
        LS_QUIET: state_match =
          is_sym(sym_a_ctrl_in, sym_a_in, SYM_QUIET) &&
          is_sym(sym_b_ctrl_in, sym_b_in, SYM_QUIET);
        LS_MASTER: state_match =
          is_sym(sym_a_ctrl_in, sym_a_in, SYM_HALT) &&
          is_sym(sym_b_ctrl_in, sym_b_in, SYM_QUIET);
        LS_NOISE: state_match =
          is_sym(sym_a_ctrl_in, sym_a_in, SYM_VIOL) ||
          is_sym(sym_b_ctrl_in, sym_b_in, SYM_VIOL);
        default: state_match = 1'b0;
      endcase
    end
  end

  assign bus_access = (avs_read_in || avs_write_in) && !st.ack;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.noise_event = 1'b0;
    next_st.code_valid = byte_valid_in;
    next_st.noise_zero_q = main_zero;
    next_st.link_zero_q = link_zero;

    if (byte_valid_in) begin
      next_st.prev_ii = pair_ii;
      next_st.prev_unknown = unknown_line_state_in;
      if (!unknown_line_state_in) begin
        next_st.prev_ls = in_als ? LS_ACTIVE : line_state_in;
      end
      // Bytes that do not fit the current line state.
      next_st.noise_event =
        (signal_detect_in && !clock_detect_in) ||
        (clock_detect_in && phy_invalid &&
         !(pair_ii || pair_jk || pair_ab)) ||
        (clock_detect_in && !phy_invalid && st.prev_ii && pair_ab);
      if (next_st.noise_event) begin
        next_st.event_count = st.event_count + EVENT_W'(1);
      end
    end

    // Clear first so a same-byte set wins.
    if (link_clear) begin
      next_st.link_flag = 1'b0;
    end
    if (link_set) begin
      next_st.link_flag = 1'b1;
    end

    // Expiry of either counter latches until software clears it.
    if (main_zero && !st.noise_zero_q) begin
      next_st.noise_sticky = 1'b1;
    end
    if (link_zero && !st.link_zero_q) begin
      next_st.link_sticky = 1'b1;
    end

    // Byte code toward the MAC.
    if (byte_valid_in) begin
      next_st.code_ctrl = 1'b1;
      if (eb_error_in) begin
        next_st.code = CODE_EB_ERROR;
      end else if (invalid_connection_in) begin
        next_st.code = CODE_INVALID_CONN;
      end else if (scrub_pair_in) begin
        next_st.code = CODE_SCRUB;
      end else if (in_als) begin
        // Data pairs pass with control bit low.
        next_st.code_ctrl = sym_a_ctrl_in || sym_b_ctrl_in;
        next_st.code = {sym_a_ctrl_in || !sym_b_ctrl_in ?
                        sym_a_in : DATA_ZERO,
                        sym_b_ctrl_in || !sym_a_ctrl_in ?
                        sym_b_in : DATA_ZERO};
      end else if (in_ils) begin
        // A stuff byte is shown as a known idle pair.
        next_st.code = {RX_STATE_IDLE, pair_ii || stuff_byte_in,
                        LS_IDLE};
      end else begin
        next_st.code = {RX_STATE_INVALID,
                        state_match || stuff_byte_in,
                        next_st.prev_ls};
      end
    end

    // Register access: one wait cycle, then the answer.
    next_st.ack = bus_access;
    if (bus_access && avs_write_in) begin
      unique case (avs_address_in)
        REG_CONTROL: next_st.stop = avs_writedata_in[CTRL_STOP];
        REG_NOISE_THRESH:
          next_st.noise_thresh = avs_writedata_in[NOISE_W-1:0];
        REG_PRESCALE_THRESH:
          next_st.prescale_thresh = avs_writedata_in[PRESCALE_W-1:0];
        REG_LINK_THRESH:
          next_st.link_thresh = avs_writedata_in[LINK_W-1:0];
        REG_STATUS: begin
          // Write one to clear; a new expiry in this cycle stays set.
          if (avs_writedata_in[STAT_NOISE_EXPIRED] &&
              !(main_zero && !st.noise_zero_q)) begin
            next_st.noise_sticky = 1'b0;
          end
          if (avs_writedata_in[STAT_LINK_EXPIRED] &&
              !(link_zero && !st.link_zero_q)) begin
            next_st.link_sticky = 1'b0;
          end
        end
        default: next_st.stop = st.stop;
      endcase
    end
    if (bus_access && avs_read_in) begin
      // Snapshots read live counts.
      unique case (avs_address_in)
        REG_CONTROL: next_st.rdata = {31'h0, st.stop};
        REG_STATUS: next_st.rdata = {28'h0, super_idle, st.link_flag,
                                     st.link_sticky, st.noise_sticky};
        REG_NOISE_THRESH: next_st.rdata = {16'h0, st.noise_thresh};
        REG_PRESCALE_THRESH: next_st.rdata = {24'h0, st.prescale_thresh};
        REG_LINK_THRESH: next_st.rdata = {24'h0, st.link_thresh};
        REG_NOISE_SNAP: next_st.rdata = {16'h0, noise_count};
        REG_PRESCALE_SNAP: next_st.rdata = {24'h0, pre_count};
        REG_LINK_SNAP: next_st.rdata = {24'h0, link_count};
        REG_NOISE_EVENTS: next_st.rdata = {16'h0, st.event_count};
        default: next_st.rdata = 32'h0;
      endcase
    end

    // Stop clears event count and link flag.
    if (st.stop) begin
      next_st.event_count = '0;
      next_st.link_flag = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st <= '0;
      st.noise_thresh <= NOISE_THRESH_RESET;
      st.prescale_thresh <= PRESCALE_THRESH_RESET;
      st.link_thresh <= LINK_THRESH_RESET;
      st.prev_ls <= LS_NO_SIGNAL;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata_out = st.rdata;
  assign avs_waitrequest_out = bus_access;
  assign code_valid_out = st.code_valid;
  assign code_ctrl_out = st.code_ctrl;
  assign code_out = st.code;
  assign super_idle_state_out = super_idle;
  assign noise_expired_out = st.noise_sticky;
  assign noise_event_out = st.noise_event;
  assign link_error_flag_out = st.link_flag;

endmodule

// ### sim/rx_mon_asserts.sv
// Purpose: Port-level checks of the line monitor and byte coder.
// Assumes: One clock; synchronous active-low reset.
// Notes: Bound from the bench.
`timescale 1ns/1ns
module rx_mon_asserts import rx_mon_pkg::*; (
  input wire logic sys_clk_in, rstn_in, avs_read_in, avs_write_in,
  input wire logic avs_waitrequest_out, byte_valid_in, eb_error_in,
  input wire logic invalid_connection_in, scrub_pair_in,
  input wire logic sym_a_ctrl_in, sym_b_ctrl_in,
  input wire logic [3:0] sym_a_in, sym_b_in,
  input wire logic [2:0] line_state_in,
  input wire logic code_valid_out, code_ctrl_out,
  input wire logic [7:0] code_out,
  input wire logic super_idle_state_out, link_error_flag_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  // ----------------------------------------------------------------------
  // Byte classes
  // ----------------------------------------------------------------------
  // Override flags win over line state, so they are left out.
  wire logic plain = byte_valid_in & ~eb_error_in & ~invalid_connection_in
    & ~scrub_pair_in;
  wire logic act = plain & (line_state_in == LS_ACTIVE);
  wire logic cc = sym_a_ctrl_in & sym_b_ctrl_in;
  sequence idle_pair;
    plain && line_state_in == LS_IDLE && cc && sym_a_in == SYM_IDLE
      && sym_b_in == SYM_IDLE;
  endsequence
  sequence idle_run;
    idle_pair [*8] ##1 idle_pair;
  endsequence
  code_latency_a: assert property (byte_valid_in |=> code_valid_out)
    else $error("code valid missing after byte");
  eb_code_a: assert property (byte_valid_in && eb_error_in
    |=> code_ctrl_out && code_out == CODE_EB_ERROR)
    else $error("buffer error code wrong");
  data_pair_a: assert property (act && !sym_a_ctrl_in && !sym_b_ctrl_in
    |=> !code_ctrl_out && code_out == {$past(sym_a_in), $past(sym_b_in)})
    else $error("data pair not forwarded");
  mixed_pair_a: assert property (act && sym_a_ctrl_in && !sym_b_ctrl_in
    |=> code_ctrl_out && code_out == {$past(sym_a_in), DATA_ZERO})
    else $error("mixed byte not zeroed");
  idle_known_a: assert property (idle_pair |=> code_out ==
    {RX_STATE_IDLE, 1'h1, LS_IDLE}) else $error("idle known code wrong");
  super_idle_a: assert property (idle_run |=> super_idle_state_out)
    else $error("super idle not raised");
  link_set_a: assert property (act && cc && sym_a_in == SYM_HALT
    && sym_b_in == SYM_HALT |=> link_error_flag_out)
    else $error("link flag not set");
  link_clear_a: assert property (act && cc && sym_a_in == SYM_START_J
    && sym_b_in == SYM_START_K |=> !link_error_flag_out)
    else $error("link flag not cleared");
  bus_answer_a: assert property ((avs_read_in || avs_write_in)
    && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
endmodule

// ### sim/mac_sink.sv
// Purpose: MAC-side sink that latches each indicate code.
// Assumes: Codes arrive as one-cycle valid pulses.
// Notes: The MAC never stalls, so nothing pushes back.
`timescale 1ns/1ns
module mac_sink (
  input wire logic sys_clk_in,
  input wire logic code_valid_in,
  input wire logic code_ctrl_in,
  input wire logic [7:0] code_in,
  output logic got_stb_out,
  output logic [8:0] got_out
);
  always_ff @(posedge sys_clk_in) begin
    got_stb_out <= code_valid_in;
    got_out <= {code_ctrl_in, code_in};
  end
endmodule

// ### sim/tb.sv
// Purpose: Self-checking bench for the line monitor.
// Assumes: Stop bit stays clear; link threshold keeps its reset value.
// Notes: Expected codes queue up and meet the sink output in order.
`timescale 1ns/1ns
module tb import rx_mon_pkg::*;;
  logic clk = '0, rstn = '0, rd = '0, wr = '0, bv = '0, ac = '0, bc = '0;
  logic stf = '0, eb = '0, ic = '0, sc = '0, wq, cv, cc, si, nx, lf, gs, ne;
  logic [3:0] adr = '0, a = '0, b = '0;
  logic [2:0] ls = '0;
  logic [31:0] wd = '0, rdat, q, r;
  logic [7:0] code;
  logic [8:0] got, e;
  logic [8:0] expq[$];
  logic [3:0] lk[5] = '{SYM_HALT, SYM_RESET, SYM_SET, SYM_END, 4'h9};
  logic [3:0] ctl[8] = '{SYM_QUIET, SYM_HALT, SYM_VIOL, SYM_END,
    SYM_RESET, SYM_SET, SYM_IDLE, SYM_START_J};
  int n_fail = 0, compares = 0;
  rx_line_monitor_byte_encoder rx_line_monitor_byte_encoder_i (
    .sys_clk_in(clk), .rstn_in(rstn), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wq),
    .byte_valid_in(bv), .sym_a_ctrl_in(ac), .sym_a_in(a),
    .sym_b_ctrl_in(bc), .sym_b_in(b), .line_state_in(ls),
    .unknown_line_state_in(1'h0), .signal_detect_in(1'h1),
    .clock_detect_in(1'h1), .stuff_byte_in(stf), .eb_error_in(eb),
    .invalid_connection_in(ic), .scrub_pair_in(sc),
    .code_valid_out(cv), .code_ctrl_out(cc), .code_out(code),
    .super_idle_state_out(si), .noise_expired_out(nx),
    .noise_event_out(ne), .link_error_flag_out(lf));
  mac_sink mac_sink_i (.sys_clk_in(clk), .code_valid_in(cv),
    .code_ctrl_in(cc), .code_in(code), .got_stb_out(gs), .got_out(got));
  initial begin
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------------
  // Expectation and drivers
  // ----------------------------------------------------------------------
  function automatic logic [8:0] want(logic [2:0] s, logic xa, xb,
      logic [3:0] va, vb, f);
    logic jk, ii, hit;
    jk = xa & xb & va == SYM_START_J & vb == SYM_START_K;
    ii = xa & xb & va == SYM_IDLE & vb == SYM_IDLE;
    hit = xa & xb & va == vb & (s == LS_HALT & va == SYM_HALT
      | s == LS_QUIET & va == SYM_QUIET);
    if (f[2]) return {1'h1, CODE_EB_ERROR};
    if (f[1]) return {1'h1, CODE_INVALID_CONN};
    if (f[0]) return {1'h1, CODE_SCRUB};
    if (s == LS_ACTIVE | jk) return {xa | xb, xb & ~xa ? DATA_ZERO : va,
      xa & ~xb ? DATA_ZERO : vb};
    if (s == LS_IDLE) return {1'h1, RX_STATE_IDLE, ii | f[3], LS_IDLE};
    return {1'h1, RX_STATE_INVALID, hit | f[3], s};
  endfunction
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic put(logic [2:0] s, logic xa, xb, logic [3:0] va, vb,
      logic [3:0] f = '0);
    {bv, ls, ac, bc, a, b} <= {1'h1, s, xa, xb, va, vb};
    {stf, eb, ic, sc} <= f;
    expq.push_back(want(s, xa, xb, va, vb, f));
    @(posedge clk);
  endtask
  task automatic gap();
    bv <= '0;
    @(posedge clk);
  endtask
  task automatic bus(logic w, logic [3:0] ad, logic [31:0] d);
    int k = 0;
    {rd, wr, adr, wd} <= {~w, w, ad, d};
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'h0 && k < 20);
    if (wq !== 1'h0) begin
      n_fail++;
      close_out();
    end
    q = rdat;
    {rd, wr} <= '0;
    @(posedge clk);
  endtask
  task automatic rdchk(logic [3:0] ad, logic [31:0] x, string w);
    bus(1'h0, ad, '0);
    cmp(w, x, q);
  endtask
  always @(posedge clk) begin
    if (gs === 1'h1) begin
      e = expq.size() > 0 ? expq.pop_front() : 'X;
      cmp("code", e, got);
    end
  end
  initial begin
    void'($urandom(74949));
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rdchk(REG_NOISE_THRESH, 32'h0000FFFF, "noise threshold");
    rdchk(4'hF, '0, "unmapped");
    // Short thresholds let the noise timer run out within a few bytes.
    bus(1'h1, REG_NOISE_THRESH, 32'h2);
    bus(1'h1, REG_PRESCALE_THRESH, 32'h1);
    put(LS_IDLE, 1, 1, SYM_IDLE, SYM_IDLE);
    gap();
    rdchk(REG_NOISE_SNAP, 32'h2, "noise snapshot");
    repeat (10) begin
      put(LS_ACTIVE, 0, 0, 4'h1, 4'h2);
      put(LS_ACTIVE, 1, 1, SYM_START_J, SYM_START_K);
    end
    gap();
    cmp("expired", '0, nx);
    repeat (30) put(LS_ACTIVE, 0, 0, 4'h3, 4'h4);
    gap();
    cmp("expired", 32'h1, nx);
    put(LS_HALT, 1, 1, SYM_HALT, SYM_HALT);
    gap();
    cmp("sticky", 32'h1, nx);
    cmp("noise event", 32'h1, ne);
    bus(1'h1, REG_STATUS, 32'h1);
    cmp("expired", '0, nx);
    foreach (lk[i]) begin
      put(LS_ACTIVE, lk[i] != 4'h9, 1, lk[i], SYM_HALT);
      gap();
      cmp("link flag", 32'h1, lf);
      put(LS_ACTIVE, 1, 1, SYM_START_J, SYM_START_K);
      gap();
      cmp("link flag", '0, lf);
    end
    rdchk(REG_LINK_SNAP, 32'hFA, "link count");
    rdchk(REG_LINK_SNAP, 32'hFA, "link count");
    for (int s = 2; s < 8; s++) begin
      if (s != 3) put(3'(s), 1, 1, SYM_QUIET, SYM_QUIET);
    end
    for (int i = 0; i < 4; i++) begin
      put(LS_IDLE, 1, 1, SYM_HALT, SYM_VIOL, 4'h1 << i);
    end
    put(LS_IDLE, 1, 1, SYM_HALT, SYM_HALT);
    repeat (8) put(LS_IDLE, 1, 1, SYM_IDLE, SYM_IDLE);
    gap();
    cmp("super idle", '0, si);
    repeat (9) put(LS_IDLE, 1, 1, SYM_IDLE, SYM_IDLE);
    gap();
    cmp("super idle", 32'h1, si);
    put(LS_IDLE, 1, 1, SYM_HALT, SYM_HALT);
    gap();
    cmp("super idle", '0, si);
    repeat (300) begin
      r = $urandom;
      put(r[0] ? LS_ACTIVE : LS_IDLE, r[1] | ~r[0], r[2] | ~r[0],
        r[1] | ~r[0] ? ctl[r[5:3]] : r[12:9],
        r[2] | ~r[0] ? ctl[r[8:6]] : r[16:13],
        r[19:17] == 3'h0 ? r[23:20] : 4'h0);
    end
    gap();
    repeat (3) @(posedge clk);
    cmp("codes left", '0, expq.size());
    close_out();
  end
endmodule
bind rx_line_monitor_byte_encoder rx_mon_asserts rx_mon_asserts_i (
  .sys_clk_in, .rstn_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
  .byte_valid_in, .eb_error_in, .invalid_connection_in, .scrub_pair_in,
  .sym_a_ctrl_in, .sym_b_ctrl_in, .sym_a_in, .sym_b_in, .line_state_in,
  .code_valid_out, .code_ctrl_out, .code_out, .super_idle_state_out,
  .link_error_flag_out);
